// ### hdl/sdcs_pkg.sv
// constants and types for the sigma-delta calibration sequencer
package sdcs_pkg;

  // modulator timing: master clock and modulator sample rate
  localparam int MCLK_HZ       = 2457600;
  localparam int MOD_HZ        = 19200;
  localparam int MOD_DIV       = MCLK_HZ / MOD_HZ;

  // output-rate periods per step
  localparam logic [1:0] ZS_PERIODS = 2'h3;
  localparam logic [1:0] FS_PERIODS = 2'h3;
  localparam logic [1:0] SELF_POST  = 2'h3;
  localparam logic [1:0] SYS_POST   = 2'h1;

  // register addresses
  localparam logic [2:0] A_SETUP  = 3'h0;
  localparam logic [2:0] A_DATA   = 3'h1;
  localparam logic [2:0] A_ZSCAL  = 3'h2;
  localparam logic [2:0] A_FSCAL  = 3'h3;
  localparam logic [2:0] A_STATUS = 3'h4;

  // setup register fields
  localparam int MODE_LSB = 0;
  localparam int GAIN_LSB = 2;
  localparam int BIP_BIT  = 5;
  localparam int RATE_LSB = 6;

  // calibration mode encodings (hi, lo)
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SELF   = 2'h1;
  localparam logic [1:0] MODE_SYS_ZS = 2'h2;
  localparam logic [1:0] MODE_SYS_FS = 2'h3;

  // reset values
  localparam logic [7:0]  SETUP_RST = 8'h00;
  localparam logic [15:0] ZS_RST    = 16'h0000;
  localparam logic [15:0] FS_RST    = 16'hffff;
  localparam logic [15:0] DATA_RST  = 16'h0000;

  // output period in modulator samples for each rate select
  localparam logic [15:0] RATE_TICKS0 = 16'h03c0;
  localparam logic [15:0] RATE_TICKS1 = 16'h0300;
  localparam logic [15:0] RATE_TICKS2 = 16'h0180;
  localparam logic [15:0] RATE_TICKS3 = 16'h0140;

  // midscale code for bipolar coding
  localparam logic [32:0] MIDSCALE = 33'h000008000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARM  = 3'b001,
    ST_ZS   = 3'b010,
    ST_FS   = 3'b011,
    ST_COEF = 3'b100,
    ST_POST = 3'b101
  } sdcs_state_t;

endpackage

// ### hdl/sdcs_scaler.sv
// offset and slope correction of one raw conversion word
module sdcs_scaler
  import sdcs_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // request
  input  wire logic        in_valid,
  input  wire logic [15:0] raw_word,
  input  wire logic [15:0] zs_word,
  input  wire logic [15:0] fs_word,
  input  wire logic        bipolar,
  // answer
  output logic             out_valid_reg,
  output logic [15:0]      code_reg
);

  logic signed [16:0] diff;
  logic signed [16:0] span;
  logic signed [32:0] num;
  logic signed [32:0] quot;
  logic signed [32:0] code_wide;
  logic [15:0]        code_next;

  // 33-bit arithmetic, saturated into 16 bits; a flat span yields code zero unipolar, midscale bipolar
  always_comb begin
    diff = $signed({1'b0, raw_word}) - $signed({1'b0, zs_word});
    span = $signed({1'b0, fs_word}) - $signed({1'b0, zs_word});
    num  = bipolar ? ($signed({{16{diff[16]}}, diff}) <<< 15) : ($signed({{16{diff[16]}}, diff}) <<< 16);
    quot = (span > 17'sh00000) ? (num / $signed({{16{span[16]}}, span})) : 33'sh000000000;
    // shorted point lands on midscale in bipolar coding
    code_wide = bipolar ? (quot + $signed(MIDSCALE)) : quot;
    if (code_wide < 33'sh000000000) begin
      code_next = 16'h0000;
    end else if (code_wide > 33'sh00000ffff) begin
      code_next = 16'hffff;
    end else begin
      code_next = code_wide[15:0];
    end
  end

  // result register, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      out_valid_reg <= 1'b0;
      code_reg      <= 16'h0000;
    end else begin
      out_valid_reg <= in_valid;
      if (in_valid) begin
        code_reg <= code_next;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_uni_zero_code: assert property (in_valid && !bipolar && raw_word == zs_word && fs_word > zs_word
    |=> out_valid_reg && code_reg == 16'h0000) else $error("unipolar zero point not at code zero");
  a_uni_full_code: assert property (in_valid && !bipolar && raw_word == fs_word && fs_word > zs_word
    |=> code_reg == 16'hffff) else $error("unipolar full-scale point not at top code");
  a_bip_mid_code: assert property (in_valid && bipolar && raw_word == zs_word && fs_word > zs_word
    |=> code_reg == 16'h8000) else $error("bipolar shorted point not at midscale");

endmodule

// ### hdl/sdcs_seq.sv
// calibration sequencer top: register port, step timing, data-ready
//
// Contract
// - calibration starts on any setup write with a nonzero mode field
// - mode (0,1) launches self-calibration
// - self zero-scale: inputs shorted, selected gain
// - self full-scale: reference over gain, same gain
// - self-calibration is three plus three periods
// - mode field returns to (0,0) when done
// - data-ready held high until fresh data word
// - self-calibration data-ready low after nine periods
// - data-ready rises within one modulator cycle
// - zero and full results stored separately
// - 33-bit offset and slope correction, 16-bit code
// - bipolar maps shorted point to midscale
// - modulator at master clock over 128, decimated
// - mode (1,0) is system zero-scale, three periods
// - mode (1,1) is system full-scale, selected gain
module sdcs_seq
  import sdcs_pkg::*;
#(
  parameter int MOD_CYCLES = MOD_DIV,
  parameter int RATE_SHIFT = 0
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  // filter result for the current output period
  input  wire logic [15:0] filt_word,
  // front-end control
  output logic             inputs_shorted,
  output logic             ref_over_gain,
  output logic [2:0]       pga_gain,
  output logic             filter_restart,
  // status pin
  output logic             data_ready_n
);

  sdcs_state_t state_reg;
  sdcs_state_t state_next;
  logic [7:0]  setup_reg;
  logic [15:0] zs_reg;
  logic [15:0] fs_reg;
  logic [15:0] data_reg;
  logic [15:0] reg_rdata_reg;
  logic        data_ready_n_n_reg;
  logic        cal_self_reg;
  logic [1:0]  step_cnt_reg;
  logic [1:0]  post_len_reg;
  logic [7:0]  mod_cnt_reg;
  logic [15:0] per_cnt_reg;
  logic [15:0] per_len;
  logic        mod_tick;
  logic        per_tick;
  logic        setup_wr;
  logic        cal_start;
  logic        step_last;
  logic [1:0]  step_len;
  logic        sc_in_valid;
  logic        sc_out_valid;
  logic [15:0] sc_code;
  logic        data_wr;
  logic        data_rd;
  logic [1:0]  mode;

  assign mode      = setup_reg[MODE_LSB +: 2];
  assign setup_wr  = reg_wr && reg_addr == A_SETUP;
  // a nonzero mode field is the only trigger
  assign cal_start = setup_wr && reg_wdata[MODE_LSB +: 2] != MODE_NORMAL;
  assign data_rd   = reg_rd && reg_addr == A_DATA;

  // output period length in modulator samples, shortened only for simulation
  always_comb begin
    case (setup_reg[RATE_LSB +: 2])
      2'h0:    per_len = RATE_TICKS0 >> RATE_SHIFT;
      2'h1:    per_len = RATE_TICKS1 >> RATE_SHIFT;
      2'h2:    per_len = RATE_TICKS2 >> RATE_SHIFT;
      default: per_len = RATE_TICKS3 >> RATE_SHIFT;
    endcase
  end

  // modulator cycle, master clock over 128
  assign mod_tick = mod_cnt_reg == 8'(MOD_CYCLES - 1);
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mod_cnt_reg <= 8'h00;
    end else if (mod_tick) begin
      mod_cnt_reg <= 8'h00;
    end else begin
      mod_cnt_reg <= mod_cnt_reg + 8'h01;
    end
  end

  // decimation to the output rate; realigned when a step begins
  assign per_tick = mod_tick && per_cnt_reg >= per_len - 16'h0001;  // a shorter rate ends at once, no wrap
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      per_cnt_reg <= 16'h0000;
    end else if ((state_reg == ST_ARM && mod_tick) || per_tick) begin
      per_cnt_reg <= 16'h0000;
    end else if (mod_tick) begin
      per_cnt_reg <= per_cnt_reg + 16'h0001;
    end
  end

  // periods in the current step; full scale keeps its own count so the two can differ
  always_comb begin
    case (state_reg)
      ST_FS:   step_len = FS_PERIODS;
      ST_POST: step_len = post_len_reg;
      default: step_len = ZS_PERIODS;
    endcase
  end

  assign step_last = per_tick && step_cnt_reg == step_len - 2'h1;

  // step sequencing; a new command restarts from any state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: state_next = ST_IDLE;
      ST_ARM: begin
        if (mod_tick) begin
          // (0,1) and (1,0) begin at zero scale, (1,1) at full scale
          state_next = (mode == MODE_SYS_FS) ? ST_FS : ST_ZS;
        end
      end
      ST_ZS: begin
        if (step_last) begin
          // self-calibration chains into full scale
          state_next = cal_self_reg ? ST_FS : ST_COEF;
        end
      end
      ST_FS: begin
        if (step_last) begin
          state_next = ST_COEF;
        end
      end
      ST_COEF: state_next = ST_POST;
      ST_POST: begin
        if (step_last) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (cal_start) begin
      state_next = ST_ARM;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // period counter within a step
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      step_cnt_reg <= 2'h0;
    end else if (state_reg != state_next || step_last) begin
      step_cnt_reg <= 2'h0;
    end else if (per_tick) begin
      step_cnt_reg <= step_cnt_reg + 2'h1;
    end
  end

  // kind of calibration and length of the closing input conversion
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cal_self_reg <= 1'b0;
      post_len_reg <= SYS_POST;
    end else if (cal_start) begin
      cal_self_reg <= reg_wdata[MODE_LSB +: 2] == MODE_SELF;
      // three zs + three fs + three input periods gives nine for self
      post_len_reg <= (reg_wdata[MODE_LSB +: 2] == MODE_SELF) ? SELF_POST : SYS_POST;
    end
  end

  // setup register; hardware clears the mode field at the end of calibration
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      setup_reg <= SETUP_RST;
    end else if (setup_wr) begin
      setup_reg <= reg_wdata[7:0];
    end else if (state_reg == ST_COEF) begin
      setup_reg[MODE_LSB +: 2] <= MODE_NORMAL;
    end
  end

  // calibration results; the sequencer wins over a host write
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      zs_reg <= ZS_RST;
      fs_reg <= FS_RST;
    end else begin
      if (state_reg == ST_ZS && step_last) begin
        zs_reg <= filt_word;
      end else if (reg_wr && reg_addr == A_ZSCAL) begin
        zs_reg <= reg_wdata;
      end
      if (state_reg == ST_FS && step_last) begin
        fs_reg <= filt_word;
      end else if (reg_wr && reg_addr == A_FSCAL) begin
        fs_reg <= reg_wdata;
      end
    end
  end

  // front-end steering; sources switched only during self-calibration steps
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      inputs_shorted <= 1'b0;
      ref_over_gain  <= 1'b0;
      pga_gain       <= 3'h0;
      filter_restart <= 1'b0;
    end else begin
      inputs_shorted <= cal_self_reg && state_next == ST_ZS;
      ref_over_gain  <= cal_self_reg && state_next == ST_FS;
      pga_gain       <= setup_wr ? reg_wdata[GAIN_LSB +: 3] : setup_reg[GAIN_LSB +: 3];
      // each zero-scale and full-scale step starts its filter fresh so old samples do not leak in
      filter_restart <= state_reg != state_next && (state_next == ST_ZS || state_next == ST_FS);
    end
  end

  // normal conversion each period in mode (0,0), and the one closing a calibration
  assign sc_in_valid = (state_reg == ST_IDLE && per_tick && !cal_start) || (state_reg == ST_POST && step_last);

  sdcs_scaler u_scaler (
    .core_clk      (core_clk),
    .reset_n       (reset_n),
    .in_valid      (sc_in_valid),
    .raw_word      (filt_word),
    .zs_word       (zs_reg),
    .fs_word       (fs_reg),
    .bipolar       (setup_reg[BIP_BIT]),
    .out_valid_reg (sc_out_valid),
    .code_reg      (sc_code)
  );

  // data register is frozen while any calibration runs
  assign data_wr = sc_out_valid && state_reg == ST_IDLE && !cal_start;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      data_reg <= DATA_RST;
    end else if (data_wr) begin
      data_reg <= sc_code;
    end
  end

  // data-ready: raised at the first modulator tick after a command, low only on a fresh word
  // a new word wins over the read that would raise it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      data_ready_n_n_reg <= 1'b1;
    end else if (data_wr) begin
      data_ready_n_n_reg <= 1'b0;
    end else if ((state_reg == ST_ARM && mod_tick) || data_rd) begin
      data_ready_n_n_reg <= 1'b1;
    end
  end
  assign data_ready_n = data_ready_n_n_reg;

  // read data one cycle after the strobe, zero elsewhere and for unmapped addresses
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata_reg <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        A_SETUP:  reg_rdata_reg <= {8'h00, setup_reg};
        A_DATA:   reg_rdata_reg <= data_reg;
        A_ZSCAL:  reg_rdata_reg <= zs_reg;
        A_FSCAL:  reg_rdata_reg <= fs_reg;
        A_STATUS: reg_rdata_reg <= {11'h000, state_reg, state_reg != ST_IDLE, data_ready_n_n_reg};
        default:  reg_rdata_reg <= 16'h0000;
      endcase
    end else begin
      reg_rdata_reg <= 16'h0000;
    end
  end
  assign reg_rdata = reg_rdata_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_arm_self;
    state_reg == ST_ARM && mod_tick && mode == MODE_SELF && !cal_start;
  endsequence
  sequence s_idle_tick;
    state_reg == ST_IDLE && per_tick && !cal_start;
  endsequence

  a_start_arms: assert property (cal_start |=> state_reg == ST_ARM) else $error("command did not arm");
  a_self_to_zs: assert property (s_arm_self |=> state_reg == ST_ZS && inputs_shorted)
    else $error("self-calibration did not begin at zero scale");
  a_zs_shorted: assert property (state_reg == ST_ZS && cal_self_reg && !$past(cal_start)
    |-> inputs_shorted && !ref_over_gain && pga_gain == setup_reg[GAIN_LSB +: 3]) else $error("zero-scale steering wrong");
  a_fs_ref: assert property (state_reg == ST_FS && cal_self_reg && !$past(cal_start)
    |-> ref_over_gain && !inputs_shorted) else $error("full-scale steering wrong");
  a_step_three: assert property (state_reg == ST_ZS && per_tick && step_cnt_reg == 2'h2 && !cal_start
    |=> state_reg != ST_ZS) else $error("zero-scale step not three periods");
  a_step_bound: assert property (state_reg == ST_ZS || state_reg == ST_FS |-> step_cnt_reg < 2'h3)
    else $error("step ran past three periods");
  a_mode_clear: assert property (state_reg == ST_COEF && !setup_wr |=> mode == MODE_NORMAL)
    else $error("mode field not cleared");
  a_data_ready_n_high: assert property (state_reg inside {ST_ZS, ST_FS, ST_COEF, ST_POST} |-> data_ready_n)
    else $error("data-ready low during calibration");
  a_data_ready_n_fall: assert property ($fell(data_ready_n) |-> $past(data_wr)) else $error("data-ready fell with no word");
  a_arm_bound: assert property ($rose(state_reg == ST_ARM) |-> ##[0:128] (state_reg != ST_ARM || data_ready_n))
    else $error("data-ready not raised within a modulator cycle");
  a_zs_store: assert property (state_reg == ST_ZS && step_last && !cal_start |=> zs_reg == $past(filt_word))
    else $error("zero-scale result not stored");
  a_mod_gap: assert property (mod_tick |=> (!mod_tick) [*8]) else $error("modulator tick too frequent");
  a_sys_fs: assert property (state_reg == ST_ARM && mod_tick && mode == MODE_SYS_FS && !cal_start
    |=> state_reg == ST_FS && !ref_over_gain) else $error("system full-scale path wrong");
  a_sys_zs_ext: assert property (state_reg == ST_ZS && !cal_self_reg && !$past(cal_start) |-> !inputs_shorted)
    else $error("system zero-scale shorted the inputs");
  a_idle_conv: assert property (s_idle_tick ##1 !cal_start |-> data_wr) else $error("normal conversion not delivered");
  a_no_cal_data: assert property (state_reg != ST_IDLE |-> !data_wr) else $error("data written during calibration");
  a_arm_raise: assert property (state_reg == ST_ARM && mod_tick && !cal_start |=> data_ready_n)
    else $error("data-ready not raised at the modulator tick");
  a_fs_store: assert property (state_reg == ST_FS && step_last && !cal_start |=> fs_reg == $past(filt_word))
    else $error("full-scale result not stored");
  a_fs_three: assert property (state_reg == ST_FS && per_tick && step_cnt_reg == 2'h2 && !cal_start
    |=> state_reg != ST_FS) else $error("full-scale step not three periods");
  a_data_word: assert property (data_wr |=> !data_ready_n && data_reg == $past(sc_code))
    else $error("fresh word not flagged");

endmodule

// ### tb/sdcs_front_model.sv
// front-end stand-in: supplies the filter word for the selected source
module sdcs_front_model #(
  parameter logic [15:0] ZS_V = 16'h1000,
  parameter logic [15:0] FS_V = 16'he000
)
(
  // front-end control from the sequencer
  input  wire logic        inputs_shorted,
  input  wire logic        ref_over_gain,
  input  wire logic [2:0]  pga_gain,
  // external input level
  input  wire logic [15:0] ain_word,
  // filter result
  output logic [15:0]      filt_word
);
  timeunit 1ns;
  timeprecision 1ps;

  // reference word depends on gain, so a wrong gain shows in the stored value
  always_comb begin
    if (inputs_shorted)
      filt_word = ZS_V;
    else if (ref_over_gain)
      filt_word = FS_V ^ {13'h0000, pga_gain};
    else
      filt_word = ain_word;
  end
endmodule

// ### tb/sdcs_seq_bench.sv
// self-checking bench for the calibration sequencer
module sdcs_seq_bench
  import sdcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // short counts keep the run small; expectations follow from these
  localparam int          MODC = 16;
  localparam int          RSH  = 6;
  localparam int          P    = (int'(RATE_TICKS0) >> RSH) * MODC;
  localparam logic [15:0] ZSV  = 16'h1000;
  localparam logic [15:0] FSV  = 16'he000;

  logic        core_clk  = 1'b0;
  logic        reset_n   = 1'b0;
  logic [2:0]  reg_addr  = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] ain_word  = 16'h1234;
  logic [15:0] reg_rdata;
  logic [15:0] filt_word;
  logic        inputs_shorted;
  logic        ref_over_gain;
  logic [2:0]  pga_gain;
  logic        filter_restart;
  logic        data_ready_n;
  logic [15:0] rv;
  int          fail_count  = 0;
  int          comparisons = 0;
  int          cyc         = 0;
  int          sh_n        = 0;
  int          rf_n        = 0;
  int          sh_b        = 0;
  int          rf_b        = 0;
  int          fr_n        = 0;
  int          fr_b        = 0;
  int          n;

  always #5 core_clk = ~core_clk;

  // cycle count and time spent in each internal calibration source
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (inputs_shorted === 1'b1) sh_n <= sh_n + 1;
    if (ref_over_gain === 1'b1) rf_n <= rf_n + 1;
    if (filter_restart === 1'b1) fr_n <= fr_n + 1;
  end

  sdcs_seq #(.MOD_CYCLES(MODC), .RATE_SHIFT(RSH)) uut (
    .core_clk       (core_clk),
    .reset_n        (reset_n),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .filt_word      (filt_word),
    .inputs_shorted (inputs_shorted),
    .ref_over_gain  (ref_over_gain),
    .pga_gain       (pga_gain),
    .filter_restart (filter_restart),
    .data_ready_n   (data_ready_n)
  );

  sdcs_front_model #(.ZS_V(ZSV), .FS_V(FSV)) fe (
    .inputs_shorted (inputs_shorted),
    .ref_over_gain  (ref_over_gain),
    .pga_gain       (pga_gain),
    .ain_word       (ain_word),
    .filt_word      (filt_word)
  );

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chkr(input string nm, input int lo, input int hi, input int got);
    comparisons++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // expected output code, 33-bit style arithmetic kept in 64 bits
  function automatic logic [15:0] code_of(input logic [15:0] r, z, f, input logic b);
    longint num;
    longint den;
    longint q;
    den = longint'(f) - longint'(z);
    num = (longint'(r) - longint'(z)) <<< (b ? 15 : 16);
    q = (den <= 0) ? 0 : num / den;
    if (b) q = q + 32768;
    if (q < 0) q = 0;
    if (q > 65535) q = 65535;
    return q[15:0];
  endfunction

  // output period in clocks for a rate select
  function automatic int per_of(input logic [1:0] r);
    logic [15:0] t;
    t = (r == 2'h0) ? RATE_TICKS0 : (r == 2'h1) ? RATE_TICKS1 : (r == 2'h2) ? RATE_TICKS2 : RATE_TICKS3;
    return (int'(t) >> RSH) * MODC;
  endfunction

  // one-cycle write strobe beside address and data
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_low(output int k);
    k = 0;
    while (data_ready_n !== 1'b0 && k < 4000) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k >= 4000) chkr("data ready wait", 0, 3999, k);
  endtask

  // command a calibration and time it to the next fresh word
  task automatic cal(input logic [1:0] m, input logic [2:0] g, input logic b, input logic [1:0] r, input int np);
    int t0;
    int k;
    wr(A_SETUP, {8'h00, r, b, g, m});
    #1;
    t0 = cyc;
    sh_b = sh_n;
    rf_b = rf_n;
    fr_b = fr_n;
    k = 0;
    // a low level here may be stale for one modulator cycle
    while (data_ready_n !== 1'b1 && k < MODC + 4) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk("ready raised", 16'h0001, {15'h0000, data_ready_n});
    wait_low(k);
    chkr("command to ready", np * per_of(r), np * per_of(r) + MODC + 8, cyc - t0);
    chk("gain copy", {13'h0000, g}, {13'h0000, pga_gain});
  endtask

  // hang guard, well above the expected run length
  initial begin
    #400000;
    fail_count++;
    conclude;
  end

  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(A_SETUP, rv);
    chk("setup reset", SETUP_RST, rv);
    rd(A_ZSCAL, rv);
    chk("zs reset", ZS_RST, rv);
    rd(A_FSCAL, rv);
    chk("fs reset", FS_RST, rv);
    rd(3'h7, rv);
    chk("unmapped", 16'h0000, rv);
    rd(A_STATUS, rv);
    chk("status reset", 16'h0001, rv);
    // normal conversion on reset coefficients
    wait_low(n);
    rd(A_DATA, rv);
    chk("normal data", code_of(16'h1234, ZS_RST, FS_RST, 1'b0), rv);
    // leave a word unread so the command meets a low ready line
    wait_low(n);
    ain_word = 16'h6000;
    cal(MODE_SELF, 3'h3, 1'b0, 2'h0, 9);
    chkr("zs step", 3 * P, 3 * P, sh_n - sh_b);
    chkr("fs step", 3 * P, 3 * P, rf_n - rf_b);
    chkr("self restarts", 2, 2, fr_n - fr_b);
    rd(A_SETUP, rv);
    chk("mode cleared", 16'h000c, rv);
    rd(A_ZSCAL, rv);
    chk("zs stored", ZSV, rv);
    rd(A_FSCAL, rv);
    chk("fs stored", FSV ^ 16'h0003, rv);
    rd(A_DATA, rv);
    chk("post cal data", code_of(16'h6000, ZSV, FSV ^ 16'h0003, 1'b0), rv);
    // bipolar: the shorted point maps to midscale
    ain_word = ZSV;
    cal(MODE_SELF, 3'h1, 1'b1, 2'h2, 9);
    rd(A_DATA, rv);
    chk("bipolar mid", 16'h8000, rv);
    // system steps use the external input only
    ain_word = 16'h0800;
    cal(MODE_SYS_ZS, 3'h1, 1'b0, 2'h1, 4);
    chkr("sys zs sources", 0, 0, (sh_n - sh_b) + (rf_n - rf_b));
    rd(A_ZSCAL, rv);
    chk("sys zs stored", 16'h0800, rv);
    rd(A_DATA, rv);
    chk("sys zs data", 16'h0000, rv);
    ain_word = 16'hf000;
    cal(MODE_SYS_FS, 3'h1, 1'b0, 2'h3, 4);
    chkr("sys fs sources", 0, 0, (sh_n - sh_b) + (rf_n - rf_b));
    chkr("sys fs restarts", 1, 1, fr_n - fr_b);
    rd(A_FSCAL, rv);
    chk("sys fs stored", 16'hf000, rv);
    rd(A_DATA, rv);
    chk("saturated data", code_of(16'hf000, 16'h0800, 16'hf000, 1'b0), rv);
    // a command mid-step restarts the sequence
    wr(A_SETUP, {8'h00, 8'h01});
    repeat (P) @(posedge core_clk);
    rd(A_STATUS, rv);
    chk("status busy", 16'h000b, rv);
    cal(MODE_SYS_ZS, 3'h2, 1'b0, 2'h0, 4);
    rd(A_SETUP, rv);
    chk("restart mode", 16'h0008, rv);
    conclude;
  end
endmodule
